// [bench/cmvc_bus_node.sv]
// Purpose: far-side bus node, makes bit ticks and the bus level
// Assumes: one bit time is four system clocks
// Notes: bench sets busy to hold the bus dominant
`timescale 1ns/1ps
module cmvc_bus_node (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_busy,
	output logic o_bit_tick,
	output logic o_rx_recessive
);
	logic [1:0] div_ff;
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			div_ff <= 2'h0;
			o_bit_tick <= 1'b0;
			o_rx_recessive <= 1'b1;
		end else begin
			div_ff <= div_ff + 2'h1;
			o_bit_tick <= (div_ff == 2'h3);
			o_rx_recessive <= !i_busy;
		end
	end
endmodule

// [bench/cmvc_top_monitor.sv]
// Purpose: port-level checks for cmvc_top
// Assumes: single clock domain
// Notes: idle count kept in helper logic
`timescale 1ns/1ps
module cmvc_top_monitor
	import cmvc_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic i_arvalid,
	input wire logic o_arready,
	input wire logic o_rvalid,
	input wire logic i_rready,
	input wire logic [31:0] o_rdata,
	input wire logic o_bvalid,
	input wire logic i_bready,
	input wire logic i_bit_tick,
	input wire logic i_rx_recessive,
	input wire logic i_cpu_idle,
	input wire logic i_abort_done,
	input wire logic i_rx_store,
	input wire cmvc_mode_t o_current_mode,
	input wire logic o_module_halt,
	input wire logic o_abort_all_tx,
	input wire logic o_capture_pulse,
	input wire logic [4:0] o_data_compare_depth
);
	// saturates so long idle never wraps back under eleven
	logic [3:0] rec_cnt_ff;
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst)
			rec_cnt_ff <= 4'h0;
		else if (i_bit_tick && !i_rx_recessive)
			rec_cnt_ff <= 4'h0;
		else if (i_bit_tick && rec_cnt_ff != 4'hf)
			rec_cnt_ff <= rec_cnt_ff + 4'h1;
	end
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (!i_nrst);
	////////////////////////////////////////////////////////////////
	a_mode_idle_gap: assert property ($changed(o_current_mode) |-> rec_cnt_ff >= IDLE_BITS)
		else $error("mode changed without bus idle");
	a_mode_no_rsvd: assert property (o_current_mode != CMVC_RSVD5 && o_current_mode != CMVC_RSVD6)
		else $error("reserved mode entered");
	a_halt_cause: assert property (o_module_halt |-> $past(i_cpu_idle))
		else $error("halt without idle");
	a_abort_clear: assert property ($fell(o_abort_all_tx) |-> $past(i_abort_done) || $past(i_abort_done, 2))
		else $error("abort cleared without done");
	a_capture_cause: assert property (o_capture_pulse |-> $past(i_rx_store))
		else $error("capture without store");
	a_depth_legal: assert property (o_data_compare_depth <= DEPTH_MAX)
		else $error("depth code invalid");
	a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid && o_rdata[31:16] == 16'h0)
		else $error("read not answered");
	a_read_clear: assert property (o_rvalid && i_rready |=> !o_rvalid)
		else $error("rvalid stuck");
	a_write_clear: assert property (o_bvalid && i_bready |=> !o_bvalid)
		else $error("bvalid stuck");
endmodule
bind cmvc_top cmvc_top_monitor u_mon (
	.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_arvalid(i_arvalid), .o_arready(o_arready),
	.o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata), .o_bvalid(o_bvalid),
	.i_bready(i_bready), .i_bit_tick(i_bit_tick), .i_rx_recessive(i_rx_recessive),
	.i_cpu_idle(i_cpu_idle), .i_abort_done(i_abort_done), .i_rx_store(i_rx_store),
	.o_current_mode(o_current_mode), .o_module_halt(o_module_halt), .o_abort_all_tx(o_abort_all_tx),
	.o_capture_pulse(o_capture_pulse), .o_data_compare_depth(o_data_compare_depth));

// [bench/tb.sv]
// Purpose: self-checking bench for cmvc_top
// Assumes: bus node model gives bit ticks
// Notes: fixed seed, random control values
`timescale 1ns/1ps
module tb;
	import cmvc_pkg::*;
	logic i_clk_sys = 1'b0, i_nrst = 1'b0, i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0;
	logic i_arvalid = 1'b0, i_rready = 1'b0, i_cpu_idle = 1'b0, i_abort_done = 1'b0, i_rx_store = 1'b0;
	logic i_rx_to_fifo = 1'b0, i_fifo_read_done = 1'b0, i_irq_error = 1'b0, i_irq_wake = 1'b0;
	logic i_irq_rx_ovf = 1'b0, i_irq_fifo_full = 1'b0, i_irq_buf = 1'b0, bus_busy = 1'b1;
	logic [7:0] i_awaddr = 8'h0, i_araddr = 8'h0;
	logic [31:0] i_wdata = 32'h0;
	logic [3:0] i_wstrb = 4'hf;
	logic [4:0] i_rx_filter = 5'h0;
	logic [5:0] i_irq_buf_num = 6'h0;
	logic i_bit_tick, i_rx_recessive, o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
	logic o_module_halt, o_abort_all_tx, o_module_clock_double, o_capture_pulse, o_window_filter;
	logic [1:0] o_bresp, o_rresp;
	logic [31:0] o_rdata, v;
	logic [4:0] o_data_compare_depth, f;
	cmvc_mode_t o_current_mode, m;
	int error_cnt = 0, checks = 0;
	cmvc_top dut (
		.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_awaddr(i_awaddr), .i_awvalid(i_awvalid),
		.o_awready(o_awready), .i_wdata(i_wdata), .i_wstrb(i_wstrb), .i_wvalid(i_wvalid),
		.o_wready(o_wready), .o_bresp(o_bresp), .o_bvalid(o_bvalid), .i_bready(i_bready),
		.i_araddr(i_araddr), .i_arvalid(i_arvalid), .o_arready(o_arready), .o_rdata(o_rdata),
		.o_rresp(o_rresp), .o_rvalid(o_rvalid), .i_rready(i_rready), .i_bit_tick(i_bit_tick),
		.i_rx_recessive(i_rx_recessive), .i_cpu_idle(i_cpu_idle), .i_abort_done(i_abort_done),
		.i_rx_store(i_rx_store), .i_rx_to_fifo(i_rx_to_fifo), .i_rx_filter(i_rx_filter),
		.i_fifo_read_done(i_fifo_read_done), .i_irq_error(i_irq_error), .i_irq_wake(i_irq_wake),
		.i_irq_rx_ovf(i_irq_rx_ovf), .i_irq_fifo_full(i_irq_fifo_full), .i_irq_buf(i_irq_buf),
		.i_irq_buf_num(i_irq_buf_num), .o_current_mode(o_current_mode), .o_module_halt(o_module_halt),
		.o_abort_all_tx(o_abort_all_tx), .o_module_clock_double(o_module_clock_double),
		.o_capture_pulse(o_capture_pulse), .o_window_filter(o_window_filter),
		.o_data_compare_depth(o_data_compare_depth));
	cmvc_bus_node u_node (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_busy(bus_busy),
		.o_bit_tick(i_bit_tick), .o_rx_recessive(i_rx_recessive));
	always #12.5 i_clk_sys = ~i_clk_sys;
	////////////////////////////////////////////////////////////////
	task chk(input string n, input logic [31:0] e, input logic [31:0] s);
		checks++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", n, e, s);
			error_cnt++;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		logic pa, pw;
		@(posedge i_clk_sys);
		i_awaddr <= a;
		i_wdata <= d;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		pa = 1'b1;
		pw = 1'b1;
		do begin
			@(posedge i_clk_sys);
			if (pa && o_awready) begin
				pa = 1'b0;
				i_awvalid <= 1'b0;
			end
			if (pw && o_wready) begin
				pw = 1'b0;
				i_wvalid <= 1'b0;
			end
		end while (!o_bvalid);
		i_bready <= 1'b0;
		chk("bresp", er, o_bresp);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		@(posedge i_clk_sys);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		i_rready <= 1'b1;
		do begin
			@(posedge i_clk_sys);
			if (o_arready) i_arvalid <= 1'b0;
		end while (!o_rvalid);
		i_rready <= 1'b0;
		chk("rresp", er, o_rresp);
		chk("rdata", e, o_rdata);
	endtask
	task store(input logic [4:0] fl, input logic tf);
		@(posedge i_clk_sys);
		i_rx_filter <= fl;
		i_rx_to_fifo <= tf;
		i_rx_store <= 1'b1;
		@(posedge i_clk_sys);
		i_rx_store <= 1'b0;
		@(posedge i_clk_sys);
	endtask
	// ends on an edge: reads see the value standing before it, drives land on it
	task tick(input int n);
		repeat (n) @(posedge i_clk_sys);
	endtask
	// reserved requests are kept but never entered
	function cmvc_mode_t nxt_mode(cmvc_mode_t cur, logic [2:0] req);
		return (req == 3'h5 || req == 3'h6) ? cur : cmvc_mode_t'(req);
	endfunction
	function logic [6:0] exp_ic(logic [4:0] s, logic [5:0] n);
		return s[4] ? IC_ERROR : s[3] ? IC_WAKE : s[2] ? IC_RX_OVF : s[1] ? IC_FIFO_FULL :
			(s[0] && n <= IC_BUF_MAX) ? {1'b0, n} : IC_NONE;
	endfunction
	task results;
		$display("errors %0d checks %0d", error_cnt, checks);
		if (error_cnt == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		#(25ns * 60000);
		error_cnt++;
		results();
	end
	////////////////////////////////////////////////////////////////
	initial begin
		void'($urandom(91064));
		tick(5);
		i_nrst <= 1'b1;
		rd(OFS_CTRL1, 32'h480, RESP_OKAY);
		rd(OFS_VEC, 32'h40, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		wr(8'h14, 32'hffff, RESP_SLVERR);
		chk("mode", CMVC_CONFIG, o_current_mode);
		m = CMVC_CONFIG;
		for (int c = 0; c < 8; c++) begin
			bus_busy <= 1'b1;
			tick(8);
			wr(OFS_CTRL1, 32'(c) << 8, RESP_OKAY);
			tick(60);
			chk("mode busy", m, o_current_mode);
			bus_busy <= 1'b0;
			tick(60);
			m = nxt_mode(m, 3'(c));
			chk("mode idle", m, o_current_mode);
			rd(OFS_CTRL1, (32'(c) << 8) | (32'(m) << 5), RESP_OKAY);
		end
		for (int i = 0; i < 6; i++) begin
			v = $urandom;
			i_cpu_idle <= v[20];
			wr(OFS_CTRL1, (v & 32'h2809) | 32'h700, RESP_OKAY);
			tick(2);
			chk("clk sel", v[11], o_module_clock_double);
			chk("window", v[0], o_window_filter);
			chk("halt", v[13] & v[20], o_module_halt);
			f = 5'($urandom % 16);
			store(f, 1'b0);
			chk("capture", v[3], o_capture_pulse);
			rd(OFS_VEC, {19'h0, f, 8'h40}, RESP_OKAY);
		end
		store(5'h14, 1'b0);
		rd(OFS_VEC, {19'h0, f, 8'h40}, RESP_OKAY);
		i_wstrb <= 4'h1;
		wr(OFS_CTRL1, 32'h1009, RESP_OKAY);
		i_wstrb <= 4'hf;
		rd(OFS_CTRL1, (v & 32'h2800) | 32'h7e9, RESP_OKAY);
		wr(OFS_CTRL1, 32'h1700, RESP_OKAY);
		tick(20);
		chk("abort set", 32'h1, o_abort_all_tx);
		i_abort_done <= 1'b1;
		tick(1);
		i_abort_done <= 1'b0;
		tick(3);
		chk("abort clr", 32'h0, o_abort_all_tx);
		rd(OFS_CTRL1, 32'h7e0, RESP_OKAY);
		for (int i = 0; i < 5; i++) begin
			v = (i == 0) ? 32'h11 : $urandom % 18;
			wr(OFS_CTRL2, v, RESP_OKAY);
			tick(2);
			chk("depth", v, o_data_compare_depth);
			rd(OFS_CTRL2, v, RESP_OKAY);
		end
		wr(OFS_CTRL2, 32'h12, RESP_OKAY);
		rd(OFS_CTRL2, v, RESP_OKAY);
		for (int i = 0; i < 12; i++) begin
			v = (i == 0) ? 32'hf01 : (i == 1) ? 32'h0 : (i == 2) ? 32'h1001 : $urandom;
			{i_irq_error, i_irq_wake, i_irq_rx_ovf, i_irq_fifo_full, i_irq_buf} <= v[4:0];
			i_irq_buf_num <= v[13:8];
			tick(3);
			rd(OFS_VEC, {19'h0, f, 1'b0, exp_ic(v[4:0], v[13:8])}, RESP_OKAY);
		end
		wr(OFS_FCTRL, 32'he005, RESP_OKAY);
		rd(OFS_FCTRL, 32'he005, RESP_OKAY);
		rd(OFS_FIFO, 32'h505, RESP_OKAY);
		store(f, 1'b1);
		rd(OFS_FIFO, 32'h605, RESP_OKAY);
		i_fifo_read_done <= 1'b1;
		tick(1);
		i_fifo_read_done <= 1'b0;
		rd(OFS_FIFO, 32'h606, RESP_OKAY);
		i_nrst <= 1'b0;
		tick(2);
		i_nrst <= 1'b1;
		rd(OFS_CTRL1, 32'h480, RESP_OKAY);
		results();
	end
endmodule

// [design/cmvc_pkg.sv]
// Purpose: shared constants and types for the can mode and vector control block
// Assumes: axi4-lite register access, 32-bit data, one word per register
// Notes: offsets are byte addresses
package cmvc_pkg;

	localparam int AXI_AW = 8;
	localparam logic [7:0] OFS_CTRL1 = 8'h00;
	localparam logic [7:0] OFS_CTRL2 = 8'h04;
	localparam logic [7:0] OFS_VEC = 8'h08;
	localparam logic [7:0] OFS_FCTRL = 8'h0c;
	localparam logic [7:0] OFS_FIFO = 8'h10;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// control one, fifo control, fifo status and vector field positions
	localparam int POS_IDLE_STOP = 13;
	localparam int POS_ABORT = 12;
	localparam int POS_CLK_SEL = 11;
	localparam int POS_REQ = 8;
	localparam int POS_CUR = 5;
	localparam int POS_CAP = 3;
	localparam int POS_WIN = 0;
	localparam int POS_RAM_BUFFER_COUNT = 13;
	localparam int POS_FBP = 8;
	localparam int POS_HIT = 8;

	typedef enum logic [2:0] {
		CMVC_NORMAL = 3'h0,
		CMVC_DISABLE = 3'h1,
		CMVC_LOOPBACK = 3'h2,
		CMVC_LISTEN_ONLY = 3'h3,
		CMVC_CONFIG = 3'h4,
		CMVC_RSVD5 = 3'h5,
		CMVC_RSVD6 = 3'h6,
		CMVC_LISTEN_ALL = 3'h7
	} cmvc_mode_t;

	localparam cmvc_mode_t RST_MODE = CMVC_CONFIG;

	localparam logic [6:0] IC_FIFO_FULL = 7'h44;
	localparam logic [6:0] IC_RX_OVF = 7'h43;
	localparam logic [6:0] IC_WAKE = 7'h42;
	localparam logic [6:0] IC_ERROR = 7'h41;
	localparam logic [6:0] IC_NONE = 7'h40;
	localparam logic [5:0] IC_BUF_MAX = 6'h0f;
	localparam logic [4:0] DEPTH_MAX = 5'h11;
	localparam logic [4:0] HIT_MAX = 5'h0f;
	localparam logic [3:0] IDLE_BITS = 4'hb;

	localparam int NUM_RX_BUF = 32;
	localparam int NUM_TX_BUF = 8;
	localparam int NUM_FILTERS = 16;
	localparam int NUM_MASKS = 3;
	localparam int MAX_DLC = 8;

	typedef struct packed {
		logic idle_stop;
		logic abort_all_tx;
		logic module_clock_select;
		cmvc_mode_t mode_request;
		logic rx_capture_link_enable;
		logic register_window_select;
	} cmvc_ctrl_t;

	localparam cmvc_ctrl_t RST_CTRL = '{1'b0, 1'b0, 1'b0, RST_MODE, 1'b0, 1'b0};

endpackage

// [design/cmvc_top.sv]
// Purpose: operating mode sequencing, control and status registers, interrupt code
// Assumes: protocol engine and message ram live outside; strobes are one-cycle pulses
// Notes: registers reached over axi4-lite, 16-bit registers in the low half of each word
//
// The implementer's own choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps

module cmvc_top
	import cmvc_pkg::*;
#(
	parameter int RX_BUFS = NUM_RX_BUF,
	parameter int TX_BUFS = NUM_TX_BUF,
	parameter int FILTERS = NUM_FILTERS,
	parameter int MASKS = NUM_MASKS
) (
	input wire logic i_clk_sys,
	input wire logic i_nrst,
	input wire logic [AXI_AW-1:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [AXI_AW-1:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic i_bit_tick,
	input wire logic i_rx_recessive,
	input wire logic i_cpu_idle,
	input wire logic i_abort_done,
	input wire logic i_rx_store,
	input wire logic i_rx_to_fifo,
	input wire logic [4:0] i_rx_filter,
	input wire logic i_fifo_read_done,
	input wire logic i_irq_error,
	input wire logic i_irq_wake,
	input wire logic i_irq_rx_ovf,
	input wire logic i_irq_fifo_full,
	input wire logic i_irq_buf,
	input wire logic [5:0] i_irq_buf_num,
	output cmvc_mode_t o_current_mode,
	output logic o_module_halt,
	output logic o_abort_all_tx,
	output logic o_module_clock_double,
	output logic o_capture_pulse,
	output logic o_window_filter,
	output logic [4:0] o_data_compare_depth
);

	////////////////////////////////////////////////////////////////////////
	// state

	cmvc_ctrl_t ctrl_ff;
	cmvc_mode_t cur_mode_ff;
	logic [3:0] recessive_cnt_ff;
	logic [4:0] depth_ff;
	logic [4:0] hit_ff;
	logic [6:0] interrupt_source_code_ff;
	logic [2:0] ram_buffer_count_ff;
	logic [4:0] fsa_ff;
	logic [5:0] fbp_ff;
	logic [5:0] fifo_next_read_pointer_ff;
	logic [AXI_AW-1:0] awaddr_ff;
	logic aw_held_ff;
	logic [31:0] wdata_ff;
	logic [3:0] wstrb_ff;
	logic w_held_ff;
	logic bus_idle;
	logic wr_fire;
	logic [15:0] rd_word;
	logic rd_hit;
	logic [6:0] nxt_interrupt_source_code;
	logic [5:0] fifo_top;

	////////////////////////////////////////////////////////////////////////
	// axi4-lite write channel: address and data taken in either order

	assign wr_fire = aw_held_ff && w_held_ff && !o_bvalid;

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			aw_held_ff <= 1'b0;
			awaddr_ff <= '0;
			o_awready <= 1'b0;
		end else begin
			o_awready <= !aw_held_ff && !(i_awvalid && o_awready);
			if (i_awvalid && o_awready) begin
				aw_held_ff <= 1'b1;
				awaddr_ff <= i_awaddr;
			end else if (wr_fire) begin
				aw_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			w_held_ff <= 1'b0;
			wdata_ff <= '0;
			wstrb_ff <= '0;
			o_wready <= 1'b0;
		end else begin
			o_wready <= !w_held_ff && !(i_wvalid && o_wready);
			if (i_wvalid && o_wready) begin
				w_held_ff <= 1'b1;
				wdata_ff <= i_wdata;
				wstrb_ff <= i_wstrb;
			end else if (wr_fire) begin
				w_held_ff <= 1'b0;
			end
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end else if (wr_fire) begin
			o_bvalid <= 1'b1;
			o_bresp <= (awaddr_ff == OFS_CTRL1 || awaddr_ff == OFS_CTRL2 ||
				awaddr_ff == OFS_FCTRL || awaddr_ff == OFS_VEC ||
				awaddr_ff == OFS_FIFO) ? RESP_OKAY : RESP_SLVERR;
		end else if (o_bvalid && i_bready) begin
			o_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// control one: software side

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ctrl_ff <= RST_CTRL;
		end else begin
			if (wr_fire && awaddr_ff == OFS_CTRL1 && wstrb_ff[1]) begin
				ctrl_ff.idle_stop <= wdata_ff[POS_IDLE_STOP];
				ctrl_ff.module_clock_select <= wdata_ff[POS_CLK_SEL];
				ctrl_ff.mode_request <= cmvc_mode_t'(wdata_ff[POS_REQ+:3]);
			end
			if (wr_fire && awaddr_ff == OFS_CTRL1 && wstrb_ff[0]) begin
				ctrl_ff.rx_capture_link_enable <= wdata_ff[POS_CAP];
				ctrl_ff.register_window_select <= wdata_ff[POS_WIN];
			end
			// a software set in the same cycle as the completion wins
			if (wr_fire && awaddr_ff == OFS_CTRL1 && wstrb_ff[1] && wdata_ff[POS_ABORT]) begin
				ctrl_ff.abort_all_tx <= 1'b1;
			end else if (i_abort_done) begin
				ctrl_ff.abort_all_tx <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// mode sequencing: bus idle is eleven recessive bits in a row

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			recessive_cnt_ff <= '0;
		end else if (i_bit_tick) begin
			if (!i_rx_recessive) begin
				recessive_cnt_ff <= '0;
			end else if (recessive_cnt_ff != IDLE_BITS) begin
				recessive_cnt_ff <= recessive_cnt_ff + 4'h1;
			end
		end
	end

	assign bus_idle = (recessive_cnt_ff == IDLE_BITS);

	// reserved requests are stored but never entered
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			cur_mode_ff <= RST_MODE;
		end else if (bus_idle && ctrl_ff.mode_request != cur_mode_ff) begin
			unique case (ctrl_ff.mode_request)
				CMVC_NORMAL,
				CMVC_DISABLE,
				CMVC_LOOPBACK,
				CMVC_LISTEN_ONLY,
				CMVC_CONFIG,
				CMVC_LISTEN_ALL: begin
					cur_mode_ff <= ctrl_ff.mode_request;
				end
				CMVC_RSVD5,
				CMVC_RSVD6: begin
					cur_mode_ff <= cur_mode_ff;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// compare depth, filter hit, fifo configuration

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			depth_ff <= '0;
		end else if (wr_fire && awaddr_ff == OFS_CTRL2 && wstrb_ff[0] && wdata_ff[4:0] <= DEPTH_MAX) begin
			depth_ff <= wdata_ff[4:0];
		end
	end

	// only messages the engine accepted ever reach here
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			hit_ff <= '0;
		end else if (i_rx_store && i_rx_filter <= HIT_MAX) begin
			hit_ff <= i_rx_filter;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			ram_buffer_count_ff <= '0;
			fsa_ff <= '0;
		end else if (wr_fire && awaddr_ff == OFS_FCTRL) begin
			if (wstrb_ff[1]) begin
				ram_buffer_count_ff <= wdata_ff[POS_RAM_BUFFER_COUNT+:3];
			end
			if (wstrb_ff[0]) begin
				fsa_ff <= wdata_ff[4:0];
			end
		end
	end

	// last buffer of the fifo area from the ram buffer count code
	always_comb begin
		unique case (ram_buffer_count_ff)
			3'h0: fifo_top = 6'h03;
			3'h1: fifo_top = 6'h05;
			3'h2: fifo_top = 6'h07;
			3'h3: fifo_top = 6'h0b;
			3'h4: fifo_top = 6'h0f;
			3'h5: fifo_top = 6'h17;
			default: fifo_top = 6'(RX_BUFS - 1);
		endcase
	end

	// fifo pointers reload on reconfiguration and wrap to the start area
	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			fbp_ff <= '0;
		end else if (wr_fire && awaddr_ff == OFS_FCTRL) begin
			fbp_ff <= {1'b0, wdata_ff[4:0]};
		end else if (i_rx_store && i_rx_to_fifo) begin
			fbp_ff <= (fbp_ff >= fifo_top) ? {1'b0, fsa_ff} : fbp_ff + 6'h01;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			fifo_next_read_pointer_ff <= '0;
		end else if (wr_fire && awaddr_ff == OFS_FCTRL) begin
			fifo_next_read_pointer_ff <= {1'b0, wdata_ff[4:0]};
		end else if (i_fifo_read_done) begin
			fifo_next_read_pointer_ff <= (fifo_next_read_pointer_ff >= fifo_top) ? {1'b0, fsa_ff} : fifo_next_read_pointer_ff + 6'h01;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt code: module sources first; buffers past 15 would land in reserved codes

	always_comb begin
		if (i_irq_error) begin
			nxt_interrupt_source_code = IC_ERROR;
		end else if (i_irq_wake) begin
			nxt_interrupt_source_code = IC_WAKE;
		end else if (i_irq_rx_ovf) begin
			nxt_interrupt_source_code = IC_RX_OVF;
		end else if (i_irq_fifo_full) begin
			nxt_interrupt_source_code = IC_FIFO_FULL;
		end else if (i_irq_buf && i_irq_buf_num <= IC_BUF_MAX) begin
			nxt_interrupt_source_code = {1'b0, i_irq_buf_num};
		end else begin
			nxt_interrupt_source_code = IC_NONE;
		end
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			interrupt_source_code_ff <= IC_NONE;
		end else begin
			interrupt_source_code_ff <= nxt_interrupt_source_code;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// axi4-lite read channel

	always_comb begin
		rd_hit = 1'b1;
		rd_word = '0;
		unique case (i_araddr)
			OFS_CTRL1: begin
				rd_word[POS_IDLE_STOP] = ctrl_ff.idle_stop;
				rd_word[POS_ABORT] = ctrl_ff.abort_all_tx;
				rd_word[POS_CLK_SEL] = ctrl_ff.module_clock_select;
				rd_word[POS_REQ+:3] = ctrl_ff.mode_request;
				rd_word[POS_CUR+:3] = cur_mode_ff;
				rd_word[POS_CAP] = ctrl_ff.rx_capture_link_enable;
				rd_word[POS_WIN] = ctrl_ff.register_window_select;
			end
			OFS_CTRL2: rd_word[4:0] = depth_ff;
			OFS_VEC: begin
				rd_word[POS_HIT+:5] = hit_ff;
				rd_word[6:0] = interrupt_source_code_ff;
			end
			OFS_FCTRL: begin
				rd_word[POS_RAM_BUFFER_COUNT+:3] = ram_buffer_count_ff;
				rd_word[4:0] = fsa_ff;
			end
			OFS_FIFO: begin
				rd_word[POS_FBP+:6] = fbp_ff;
				rd_word[5:0] = fifo_next_read_pointer_ff;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= '0;
			o_rresp <= RESP_OKAY;
		end else begin
			o_arready <= !o_rvalid && !(i_arvalid && o_arready);
			if (i_arvalid && o_arready) begin
				o_rvalid <= 1'b1;
				o_rdata <= {16'h0000, rd_word};
				o_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (o_rvalid && i_rready) begin
				o_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs toward the protocol engine, all registered
	// engine handles frames, rtr replies, priorities, wake filter

	always_ff @(posedge i_clk_sys or negedge i_nrst) begin
		if (!i_nrst) begin
			o_current_mode <= RST_MODE;
			o_module_halt <= 1'b0;
			o_abort_all_tx <= 1'b0;
			o_module_clock_double <= 1'b0;
			o_capture_pulse <= 1'b0;
			o_window_filter <= 1'b0;
			o_data_compare_depth <= '0;
		end else begin
			o_current_mode <= cur_mode_ff;
			o_module_halt <= ctrl_ff.idle_stop && i_cpu_idle;
			o_abort_all_tx <= ctrl_ff.abort_all_tx;
			o_module_clock_double <= ctrl_ff.module_clock_select;
			o_capture_pulse <= ctrl_ff.rx_capture_link_enable && i_rx_store;
			o_window_filter <= ctrl_ff.register_window_select;
			o_data_compare_depth <= depth_ff;
		end
	end

endmodule
